// [hw/trsw_top.sv]
// Behaviour
// - message byte follows status or first message
// - status or first byte per termination
// - first block layout four words
// - second block when cdb over six
// - target response flag bit 0 copied from request tmo
// - continued block flag only second block
// - retried flag when retries needed
// - fault flag on unrecovered error only
// - completion flag set when finished
// - error code into error byte
// - bus released flag on disconnect
// - check condition sent flag
// - message received flag marks valid field
// - command bytes flag marks cdb valid
// - sequence code in bits 7:4
// - cdb length counts returned bytes
// - atn message captured into status
// - cdb fields hold 6/10/12 bytes
// - each block carries request identifier
// - normal: status, message, bus free
// - disconnect: first msg, message, bus free
`default_nettype none
`include "trsw_cfg.svh"
module trsw_top
   import trsw_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic req_valid,
   input wire trsw_req_s req,
   input wire logic cdb_valid,
   input wire logic [7:0] cdb_byte,
   input wire logic atn_msg_valid,
   input wire logic [7:0] atn_msg_byte,
   input wire logic [3:0] atn_seq_code,
   input wire logic scsi_done,
   input wire trsw_result_s result,
   input wire logic tx_ack,
   input wire logic wr_ready,
   output logic busy,
   output logic tx_req,
   output logic tx_is_status,
   output logic [7:0] tx_byte,
   output logic bus_free,
   output logic wr_valid,
   output logic wr_second,
   output trsw_word_s wr_word,
   output logic status_done
);
   // ==========================================
   // state
   typedef struct packed {
      trsw_state_e st;
      trsw_req_s rq;
      logic [3:0] cdb_len;
      logic msg_valid;
      logic [7:0] msg_byte;
      logic [3:0] seq;
      logic [1:0] wd;
      logic blk2;
      logic wv;
      logic w2;
      trsw_word_s ww;
      logic done;
      logic [3:0] rd_idx;
      logic sent;
      logic fin;
   } trsw_top_s;
   trsw_top_s r, next_r;
   logic [7:0] cdb_rd;
   logic seq_start;
   logic seq_done;
   logic seq_req;
   logic seq_stat;
   logic [7:0] seq_byte;
   logic seq_free;
   trsw_result_s res;
   logic [7:0] cdb_hold [0:5];
   logic [3:0] cdb_fill;

   function automatic logic [7:0] flags_byte(input logic second, input logic tmo,
                                             input trsw_result_s x);
      logic [7:0] f;
      f = 8'h00;
      f[`TRSW_FL_TMS] = tmo;
      f[`TRSW_FL_CSB] = second;
      f[`TRSW_FL_RTY] = x.retried;
      f[`TRSW_FL_ERR] = x.fault;
      f[`TRSW_FL_CC] = 1'b1;
      return f;
   endfunction

   // ==========================================
   // cdb store and message sequencer
   trsw_cdb_mem u_mem (
      .clk(clk),
      .nrst(nrst),
      .wr_en(cdb_valid && r.st != TRSW_IDLE && r.cdb_len < `TRSW_CDB_MAX),
      .wr_idx(r.cdb_len),
      .wr_data(cdb_byte),
      .rd_idx(r.rd_idx),
      .rd_data(cdb_rd)
   );

   assign seq_start = (r.st == TRSW_SEND);
   trsw_msg_seq u_seq (
      .clk(clk),
      .nrst(nrst),
      .start(seq_start),
      .status_first(r.rq.normal_termination_ctl),
      .byte_a(r.rq.status_or_first_msg),
      .byte_b(r.rq.message_byte),
      .tx_ack(tx_ack),
      .tx_req(seq_req),
      .tx_is_status(seq_stat),
      .tx_byte(seq_byte),
      .bus_free(seq_free),
      .done(seq_done)
   );
   assign res = result;

   // ==========================================
   // six cdb bytes fetched per block, only once scsi activity is over,
   // so no byte still in flight is read stale
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cdb_fill <= 4'h0;
      end else if (r.st == TRSW_WRITE && r.wd == 2'd1) begin
         cdb_fill <= 4'h0;
      end else if (r.st == TRSW_WAIT && r.fin && cdb_fill < 4'h8) begin
         cdb_fill <= cdb_fill + 4'h1;
      end
   end
   always_ff @(posedge clk) begin
      // index and memory read are both registered: two cycles of lag
      if (r.st == TRSW_WAIT && cdb_fill > 4'h1 && cdb_fill < 4'h8) begin
         cdb_hold[3'(cdb_fill - 4'h2)] <= cdb_rd;
      end
   end

   // ==========================================
   // main sequence
   always_comb begin
      logic [7:0] cs;
      logic [3:0] base;
      cs = 8'h00;
      base = r.blk2 ? `TRSW_CDB_FIRST : 4'h0;
      next_r = r;
      next_r.done = 1'b0;
      cs[`TRSW_CS_DIS] = res.bus_released;
      cs[`TRSW_CS_CHK] = res.check_sent;
      cs[`TRSW_CS_MSG] = r.msg_valid;
      cs[`TRSW_CS_CMD] = (r.cdb_len != 4'h0);
      cs[7:4] = r.msg_valid ? r.seq : 4'h0;
      if (cdb_valid && r.st != TRSW_IDLE && r.cdb_len < `TRSW_CDB_MAX) begin
         next_r.cdb_len = r.cdb_len + 4'h1;
      end
      if (atn_msg_valid && r.st != TRSW_IDLE) begin
         next_r.msg_valid = 1'b1;
         next_r.msg_byte = atn_msg_byte;
         next_r.seq = (atn_seq_code > `TRSW_SEQ_MAX) ? 4'h0 : atn_seq_code;
      end
      case (r.st)
         TRSW_IDLE: begin
            if (req_valid) begin
               next_r.rq = req;
               next_r.cdb_len = 4'h0;
               next_r.msg_valid = 1'b0;
               next_r.seq = 4'h0;
               next_r.msg_byte = 8'h00;
               next_r.sent = 1'b0;
               next_r.fin = 1'b0;
               next_r.st = (req.normal_termination_ctl || req.disconnect_termination_ctl)
                  ? TRSW_SEND : TRSW_WAIT;
            end
         end
         TRSW_SEND: begin
            next_r.st = TRSW_WAIT;
            next_r.sent = 1'b1;
         end
         TRSW_WAIT: begin
            next_r.rd_idx = base + cdb_fill;
            if (scsi_done || (r.sent && seq_done)) begin
               next_r.fin = 1'b1;
            end
            if (r.fin && cdb_fill == 4'h8) begin
               next_r.st = TRSW_WRITE;
               next_r.wd = 2'd0;
            end
         end
         TRSW_WRITE: begin
            if (!r.wv || wr_ready) begin
               next_r.wv = 1'b1;
               next_r.w2 = r.blk2;
               case (r.wd)
                  2'd0: next_r.ww = '{off: `TRSW_OFS_ID, data: r.rq.cmd_id};
                  2'd1: next_r.ww = '{off: `TRSW_OFS_FLAGS,
                        data: {r.blk2 ? 8'h00 : cs, 8'h00, res.error_code,
                               flags_byte(r.blk2, r.rq.tmo, res)}};
                  2'd2: next_r.ww = r.blk2
                        ? '{off: `TRSW_OFS_MSG, data: {cdb_hold[0], cdb_hold[1],
                            cdb_hold[2], cdb_hold[3]}}
                        : '{off: `TRSW_OFS_MSG, data: {r.msg_byte, 4'h0, r.cdb_len,
                            cdb_hold[0], cdb_hold[1]}};
                  default: next_r.ww = r.blk2
                        ? '{off: `TRSW_OFS_CDB, data: {cdb_hold[4], cdb_hold[5],
                            16'h0000}}
                        : '{off: `TRSW_OFS_CDB, data: {cdb_hold[2], cdb_hold[3],
                            cdb_hold[4], cdb_hold[5]}};
               endcase
               if (r.wd == 2'd3) begin
                  next_r.st = TRSW_DONE;
               end else begin
                  next_r.wd = r.wd + 2'd1;
               end
            end
         end
         TRSW_DONE: begin
            if (wr_ready || !r.wv) begin
               next_r.wv = 1'b0;
               if (!r.blk2 && r.cdb_len > `TRSW_CDB_FIRST) begin
                  next_r.blk2 = 1'b1;
                  next_r.st = TRSW_WAIT;
               end else begin
                  next_r.blk2 = 1'b0;
                  next_r.done = 1'b1;
                  next_r.st = TRSW_IDLE;
               end
            end
         end
         default: next_r.st = TRSW_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         r <= '0;
         r.st <= TRSW_IDLE;
      end else begin
         r <= next_r;
      end
   end

   // ==========================================
   // outputs, all registered
   always_ff @(posedge clk) begin
      if (!nrst) begin
         busy <= 1'b0;
         tx_req <= 1'b0;
         tx_is_status <= 1'b0;
         tx_byte <= 8'h00;
         bus_free <= 1'b0;
         status_done <= 1'b0;
      end else begin
         busy <= (next_r.st != TRSW_IDLE);
         tx_req <= seq_req && !tx_ack;
         tx_is_status <= seq_stat;
         tx_byte <= seq_byte;
         bus_free <= seq_free;
         status_done <= next_r.done;
      end
   end
   assign wr_valid = r.wv;
   assign wr_second = r.w2;
   assign wr_word = r.ww;
endmodule
`default_nettype wire

// [hw/trsw_cfg.svh]
`ifndef TRSW_CFG_SVH
`define TRSW_CFG_SVH
// status block word offsets (bytes)
`define TRSW_OFS_ID 4'h0
`define TRSW_OFS_FLAGS 4'h4
`define TRSW_OFS_MSG 4'h8
`define TRSW_OFS_CDB 4'hc
// flags byte bits
`define TRSW_FL_TMS 0
`define TRSW_FL_CSB 2
`define TRSW_FL_RTY 5
`define TRSW_FL_ERR 6
`define TRSW_FL_CC 7
// command status flags byte bits
`define TRSW_CS_DIS 0
`define TRSW_CS_CHK 1
`define TRSW_CS_MSG 2
`define TRSW_CS_CMD 3
`define TRSW_CS_SEQ_LO 4
// cdb bytes held in first block
`define TRSW_CDB_FIRST 4'h6
`define TRSW_CDB_MAX 4'hc
`define TRSW_SEQ_MAX 4'h9
`endif

// [hw/trsw_pkg.sv]
`default_nettype none
package trsw_pkg;
   typedef struct packed {
      logic [31:0] cmd_id;
      logic tmo;
      logic normal_termination_ctl;
      logic disconnect_termination_ctl;
      logic linked_termination_ctl;
      logic [7:0] status_or_first_msg;
      logic [7:0] message_byte;
   } trsw_req_s;
   typedef struct packed {
      logic bus_released;
      logic check_sent;
      logic msg_valid;
      logic [7:0] msg_byte;
      logic [3:0] seq_code;
      logic retried;
      logic fault;
      logic [7:0] error_code;
   } trsw_result_s;
   typedef struct packed {
      logic [3:0] off;
      logic [31:0] data;
   } trsw_word_s;
   typedef enum logic [3:0] {
      TRSW_MSG_IDLE = 4'b0001,
      TRSW_MSG_FIRST = 4'b0010,
      TRSW_MSG_SECOND = 4'b0100,
      TRSW_MSG_FREE = 4'b1000
   } trsw_msg_e;
   typedef enum logic [4:0] {
      TRSW_IDLE = 5'b00001,
      TRSW_SEND = 5'b00010,
      TRSW_WAIT = 5'b00100,
      TRSW_WRITE = 5'b01000,
      TRSW_DONE = 5'b10000
   } trsw_state_e;
endpackage
`default_nettype wire

// [hw/trsw_cdb_mem.sv]
`default_nettype none
// 12-byte cdb store; read data registered
module trsw_cdb_mem
   import trsw_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic wr_en,
   input wire logic [3:0] wr_idx,
   input wire logic [7:0] wr_data,
   input wire logic [3:0] rd_idx,
   output logic [7:0] rd_data
);
   logic [7:0] mem [0:11];
   always_ff @(posedge clk) begin
      if (wr_en && wr_idx < 4'hc) begin
         mem[wr_idx] <= wr_data;
      end
      if (!nrst) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= (rd_idx < 4'hc) ? mem[rd_idx] : 8'h00;
      end
   end
endmodule
`default_nettype wire

// [hw/trsw_msg_seq.sv]
`default_nettype none
`include "trsw_cfg.svh"
// sends two bytes on the scsi side, then requests bus free
module trsw_msg_seq
   import trsw_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic start,
   input wire logic status_first,
   input wire logic [7:0] byte_a,
   input wire logic [7:0] byte_b,
   input wire logic tx_ack,
   output logic tx_req,
   output logic tx_is_status,
   output logic [7:0] tx_byte,
   output logic bus_free,
   output logic done
);
   typedef struct packed {
      trsw_msg_e st;
      logic req;
      logic is_status;
      logic [7:0] data;
      logic [7:0] second;
      logic free;
      logic done;
   } trsw_seq_s;
   trsw_seq_s r, next_r;
   always_comb begin
      next_r = r;
      next_r.free = 1'b0;
      next_r.done = 1'b0;
      case (r.st)
         TRSW_MSG_IDLE: begin
            if (start) begin
               next_r.st = TRSW_MSG_FIRST;
               next_r.req = 1'b1;
               next_r.is_status = status_first;
               next_r.data = byte_a;
               next_r.second = byte_b;
            end
         end
         TRSW_MSG_FIRST: begin
            if (tx_ack) begin
               next_r.st = TRSW_MSG_SECOND;
               next_r.is_status = 1'b0;
               next_r.data = r.second;
            end
         end
         TRSW_MSG_SECOND: begin
            if (tx_ack) begin
               next_r.st = TRSW_MSG_FREE;
               next_r.req = 1'b0;
            end
         end
         TRSW_MSG_FREE: begin
            next_r.st = TRSW_MSG_IDLE;
            next_r.free = 1'b1;
            next_r.done = 1'b1;
         end
         default: next_r.st = TRSW_MSG_IDLE;
      endcase
   end
   always_ff @(posedge clk) begin
      if (!nrst) begin
         r <= '{st: TRSW_MSG_IDLE, req: 1'b0, is_status: 1'b0, data: 8'h00,
                second: 8'h00, free: 1'b0, done: 1'b0};
      end else begin
         r <= next_r;
      end
   end
   assign tx_req = r.req;
   assign tx_is_status = r.is_status;
   assign tx_byte = r.data;
   assign bus_free = r.free;
   assign done = r.done;
endmodule
`default_nettype wire

// [sim/trsw_assertions.sv]
`default_nettype none
// ==========
// port checker
module trsw_checker
   import trsw_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic busy,
   input wire logic tx_req,
   input wire logic tx_ack,
   input wire logic [7:0] tx_byte,
   input wire logic wr_valid,
   input wire logic wr_ready,
   input wire logic wr_second,
   input wire trsw_word_s wr_word,
   input wire logic status_done
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_tx_hold;
      tx_req && !tx_ack |=> tx_req && $stable(tx_byte);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("tx byte moved before ack");
   property p_tx_busy;
      tx_req |-> busy;
   endproperty
   a_tx_busy: assert property (p_tx_busy) else $error("tx request while idle");
   property p_wr_hold;
      wr_valid && !wr_ready |=> wr_valid && $stable(wr_word) && $stable(wr_second);
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("status word moved before ready");
   // wr_valid drops between blocks, so this checks word order within a block, never the restart at 0
   property p_order;
      wr_valid && $past(wr_valid && wr_ready) |-> wr_word.off == $past(wr_word.off) + 4'h4;
   endproperty
   a_order: assert property (p_order) else $error("status word out of order");
   property p_flags;
      wr_valid && wr_word.off == 4'h4 |-> wr_word.data[7] && wr_word.data[2] == wr_second
         && wr_word.data[4:3] == 2'b00 && !wr_word.data[1];
   endproperty
   a_flags: assert property (p_flags) else $error("flags byte wrong");
   property p_resv1;
      wr_valid && wr_word.off == 4'h4 |-> wr_word.data[23:16] == 8'h00
         && (!wr_second || wr_word.data[31:24] == 8'h00);
   endproperty
   a_resv1: assert property (p_resv1) else $error("reserved byte not zero");
   property p_resv2;
      wr_valid && wr_second && wr_word.off == 4'hc |-> wr_word.data[15:0] == 16'h0000;
   endproperty
   a_resv2: assert property (p_resv2) else $error("second block tail not zero");
   property p_done;
      status_done |=> !status_done;
   endproperty
   a_done: assert property (p_done) else $error("done longer than one cycle");
endmodule
bind trsw_top trsw_checker u_trsw_checker (.clk, .nrst, .busy, .tx_req, .tx_ack, .tx_byte,
   .wr_valid, .wr_ready, .wr_second, .wr_word, .status_done);
`default_nettype wire

// [sim/trsw_partner.sv]
`default_nettype none
// ==========
// initiator byte sink and host memory
module trsw_partner
   import trsw_pkg::*;
(
   input wire logic clk,
   input wire logic [4:0] ack_dly,
   input wire logic stall,
   input wire logic tx_req,
   input wire logic [7:0] tx_byte,
   input wire logic tx_is_status,
   input wire logic wr_valid,
   input wire logic wr_second,
   input wire trsw_word_s wr_word,
   output logic tx_ack,
   output logic wr_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [8:0] txq [$];
   logic [31:0] blk [2][4];
   int nwords = 0;
   int cnt = 0;
   initial begin
      tx_ack = 1'b0;
      wr_ready = 1'b0;
   end
   always @(posedge clk) begin
      tx_ack <= 1'b0;
      if (tx_req && !tx_ack) begin
         cnt <= cnt + 1;
         if (cnt >= ack_dly) begin
            tx_ack <= 1'b1;
            txq.push_back({tx_is_status, tx_byte});
            cnt <= 0;
         end
      end
      // stall toggles ready to exercise the hold side
      wr_ready <= stall ? ~wr_ready : 1'b1;
      if (wr_valid && wr_ready) begin
         blk[wr_second][wr_word.off[3:2]] <= wr_word.data;
         nwords <= nwords + 1;
      end
   end
endmodule
`default_nettype wire

// [sim/test_trsw_top.sv]
`default_nettype none
module test_trsw_top
   import trsw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, nrst, req_valid, cdb_valid, atn_msg_valid, scsi_done, tx_ack, wr_ready;
   logic busy, tx_req, tx_is_status, bus_free, wr_valid, wr_second, status_done, stall;
   logic [7:0] cdb_byte, atn_msg_byte, tx_byte;
   logic [3:0] atn_seq_code;
   logic [4:0] ack_dly;
   trsw_req_s req;
   trsw_result_s result;
   trsw_word_s wr_word;
   int fail_count = 0, compares = 0, bf = 0, cyc = 0;
   trsw_top u_trsw_top (.clk, .nrst, .req_valid, .req, .cdb_valid, .cdb_byte, .atn_msg_valid,
      .atn_msg_byte, .atn_seq_code, .scsi_done, .result, .tx_ack, .wr_ready, .busy, .tx_req,
      .tx_is_status, .tx_byte, .bus_free, .wr_valid, .wr_second, .wr_word, .status_done);
   trsw_partner u_trsw_partner (.clk, .ack_dly, .stall, .tx_req, .tx_byte, .tx_is_status,
      .wr_valid, .wr_second, .wr_word, .tx_ack, .wr_ready);
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (bus_free === 1'b1) bf <= bf + 1;
      if (cyc == 3000) begin
         fail_count++;
         report_and_stop();
      end
   end
   // ==========
   // access tasks
   task automatic step;
      @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [7:0] cb(input int i);
      return 8'h10 + i[7:0];
   endfunction
   task automatic run(input logic [31:0] id, input logic t, n, d, input logic [7:0] s, m,
      input int ncdb, input logic a, input logic [3:0] sq, input trsw_result_s r,
      input logic [4:0] dly, input logic stl);
      int ncl;
      logic [7:0] fl;
      for (int k = 0; k < 50 && busy !== 1'b0; k++) step();
      ncl = ncdb > 12 ? 12 : ncdb;
      fl = {1'b1, r.fault, r.retried, 4'h0, t};
      u_trsw_partner.txq.delete();
      u_trsw_partner.nwords = 0;
      bf = 0;
      ack_dly = dly;
      stall = stl;
      result = r;
      req = '{id, t, n, d, 1'b0, s, m};
      req_valid = 1'b1;
      step();
      req_valid = 1'b0;
      for (int i = 0; i < ncdb; i++) begin
         cdb_valid = 1'b1;
         cdb_byte = cb(i);
         // a second request while busy must not disturb the first
         req_valid = (i == 2);
         req.cmd_id = ~id;
         step();
      end
      cdb_valid = 1'b0;
      req_valid = 1'b0;
      atn_msg_valid = a;
      atn_msg_byte = 8'h80 + {4'h0, sq};
      atn_seq_code = sq;
      step();
      atn_msg_valid = 1'b0;
      scsi_done = !(n || d);
      step();
      scsi_done = 1'b0;
      for (int k = 0; k < 400 && status_done !== 1'b1; k++) step();
      chk({31'h0, status_done}, 32'h1);
      chk(u_trsw_partner.txq.size(), (n || d) ? 2 : 0);
      if (n || d) begin
         chk({23'h0, u_trsw_partner.txq[0]}, {23'h0, n, s});
         chk({23'h0, u_trsw_partner.txq[1]}, {23'h0, 1'b0, m});
      end
      chk(bf, (n || d) ? 1 : 0);
      chk(u_trsw_partner.nwords, ncl > 6 ? 8 : 4);
      chk(u_trsw_partner.blk[0][0], id);
      chk(u_trsw_partner.blk[0][1], {a ? sq : 4'h0, 1'b1, a, r.check_sent, r.bus_released,
         8'h00, r.error_code, fl});
      chk(u_trsw_partner.blk[0][2] & {a ? 8'hff : 8'h00, 24'hffffff},
         {a ? 8'h80 + {4'h0, sq} : 8'h00, ncl[7:0], cb(0), cb(1)});
      chk(u_trsw_partner.blk[0][3], {cb(2), cb(3), cb(4), cb(5)});
      if (ncl > 6) begin
         chk(u_trsw_partner.blk[1][0], id);
         chk(u_trsw_partner.blk[1][1], {16'h0, r.error_code, fl | 8'h04});
         chk(u_trsw_partner.blk[1][2], {cb(6), cb(7), cb(8), cb(9)});
         chk(u_trsw_partner.blk[1][3] & (ncl == 12 ? 32'hffffffff : 32'h0000ffff),
            ncl == 12 ? {cb(10), cb(11), 16'h0} : 32'h0);
      end
      $display("test for identifier %h done", id);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ==========
   // tests
   initial begin
      nrst = 1'b0;
      {req_valid, cdb_valid, atn_msg_valid, scsi_done, stall} = 5'h00;
      {cdb_byte, atn_msg_byte, atn_seq_code, ack_dly} = 25'h0;
      req = '0;
      result = '0;
      repeat (6) @(posedge clk);
      #1 nrst = 1'b1;
      run(32'h0000a001, 1'b1, 1'b1, 1'b0, 8'h02, 8'h00, 6, 1'b1, 4'h3,
         trsw_result_s'({2'b01, 13'h0, 2'b10, 8'h12}), 5'd20, 1'b0);
      run(32'hffff0003, 1'b0, 1'b0, 1'b1, 8'h02, 8'h04, 13, 1'b0, 4'h7,
         trsw_result_s'({2'b10, 13'h0, 2'b01, 8'h34}), 5'd25, 1'b1);
      run(32'h5a5a0007, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 10, 1'b1, 4'h9,
         trsw_result_s'(25'h0), 5'd0, 1'b1);
      report_and_stop();
   end
endmodule
`default_nettype wire
